/* File: core/frr_pkg.sv */
// Constants, types and field layout of the fault record serial readout.
//
// Function
// - A short alone releases the clock flag and keeps the data flag low.
// - High-side short detection sets that phase's high-side record bit.
// - Low-side short detection sets that phase's low-side record bit.
// - Simultaneous high and low detections both land in the record.
// - Ten-bit record accumulates every detection, never overwriting.
// - Record kept until reset pin low, power cycle or completed readout.
// - Logic undervoltage clears the record and releases both flags meanwhile.
// - Record order: high-side A,B,C first, then low-side A,B,C.
// - Position six (FRR_POS_VR) holds the regulator undervoltage bit.
// - Last three positions hold bootstrap undervoltage A, B, C.
// - Both flags are open drain; a fault present releases one or both of them high.
// - No serial access while the device pulls the clock flag low.
// - Controller pulls clock flag low; device shows the first record bit.
// - Each high-then-low clock pulse advances to the next of ten bits.
// - Pulse after the last bit clears record and pulls both flags low.
// - Unlatched conditions still active reappear on the flags at once.
// - Regulator undervoltage record bit stays latched after the flags clear.
// - With stop-on-fault off, shorts are still latched in the record.
// - Bootstrap undervoltage state latches until reset pin or readout.
package frr_pkg;

   // ==========================================================
   // Record layout
   localparam int FRR_REC_W = 10;
   localparam int FRR_IDX_W = 4;
   localparam logic [9:0] FRR_REC_RESET = 10'h000;
   localparam logic [3:0] FRR_IDX_FIRST = 4'h0;
   localparam logic [3:0] FRR_IDX_LAST = 4'h9;
   localparam int FRR_POS_AH = 0;
   localparam int FRR_POS_BH = 1;
   localparam int FRR_POS_CH = 2;
   localparam int FRR_POS_AL = 3;
   localparam int FRR_POS_BL = 4;
   localparam int FRR_POS_CL = 5;
   localparam int FRR_POS_VR = 6;
   localparam int FRR_POS_VA = 7;
   localparam int FRR_POS_VB = 8;
   localparam int FRR_POS_VC = 9;

   // ==========================================================
   // Synchroniser lanes
   localparam int FRR_SYNC_W = 15;
   localparam int FRR_LN_ESF = 10;
   localparam int FRR_LN_LUV = 11;
   localparam int FRR_LN_OT = 12;
   localparam int FRR_LN_PRST = 13;
   localparam int FRR_LN_CLK = 14;

   // ==========================================================
   // Timing counts in system clock cycles
   localparam int FRR_FILT_CYC = 2;
   localparam logic [2:0] FRR_SETTLE_CYC = 3'h4;

   // ==========================================================
   // Readout sequencer
   typedef enum logic [1:0] {
      FRR_IDLE,
      FRR_SHIFT
   } frr_state_type;

endpackage : frr_pkg

/* File: core/frr_sync.sv */
// Two flip-flop synchroniser for a vector of asynchronous inputs.
`timescale 1ns/10ps
module frr_sync #(
   parameter int W = 1
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta_ff;

   if (W < 1) begin : g_bad_width
      $error("frr_sync: width must be at least one");
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         meta_ff <= '0;
         sync_o <= '0;
      end else begin
         meta_ff <= async_i;
         sync_o <= meta_ff;
      end
   end
endmodule : frr_sync

/* File: core/frr_link_edge.sv */
// Glitch filter and edge finder for the synchronised clock flag.
`timescale 1ns/10ps
module frr_link_edge
   import frr_pkg::*;
#(
   parameter int FILT = FRR_FILT_CYC
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic level_i,
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);
   logic [3:0] cnt_ff;
   logic [3:0] nxt_cnt;
   wire differ = (level_i != level_o);
   wire accept = differ && (nxt_cnt >= 4'(FILT));

   if (FILT < 1 || FILT > 15) begin : g_bad_filt
      $error("frr_link_edge: filter length must be 1 to 15");
   end

   assign nxt_cnt = differ ? cnt_ff + 4'h1 : 4'h0;

   // A new level is taken only once it has held for FILT cycles.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         cnt_ff <= 4'h0;
         level_o <= 1'b0;
         rise_o <= 1'b0;
         fall_o <= 1'b0;
      end else begin
         cnt_ff <= accept ? 4'h0 : nxt_cnt;
         level_o <= accept ? level_i : level_o;
         rise_o <= accept && level_i;
         fall_o <= accept && !level_i;
      end
   end
endmodule : frr_link_edge

/* File: core/frr_fault_record.sv */
// Fault recorder with serial readout over two open-drain fault flags.
`timescale 1ns/10ps
module frr_fault_record
   import frr_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic reset_pin_n_i,
   input wire logic logic_undervolt_i,
   input wire logic overtemp_i,
   input wire logic stop_on_fault_enable_i,
   input wire logic phase_a_high_vds_i,
   input wire logic phase_b_high_vds_i,
   input wire logic phase_c_high_vds_i,
   input wire logic phase_a_low_vds_i,
   input wire logic phase_b_low_vds_i,
   input wire logic phase_c_low_vds_i,
   input wire logic regulator_undervoltage_i,
   input wire logic bootstrap_a_undervolt_i,
   input wire logic bootstrap_b_undervolt_i,
   input wire logic bootstrap_c_undervolt_i,
   input wire logic fault_clock_flag_i,
   output logic fault_data_flag_o,
   output logic fault_data_flag_oe_o,
   output logic fault_clock_flag_o,
   output logic fault_clock_flag_oe_o,
   output logic [FRR_REC_W-1:0] fault_record_o
);

   // ==========================================================
   // Input synchronisation
   wire [FRR_SYNC_W-1:0] raw_in;
   logic [FRR_SYNC_W-1:0] syn;

   assign raw_in[FRR_POS_AH] = phase_a_high_vds_i;
   assign raw_in[FRR_POS_BH] = phase_b_high_vds_i;
   assign raw_in[FRR_POS_CH] = phase_c_high_vds_i;
   assign raw_in[FRR_POS_AL] = phase_a_low_vds_i;
   assign raw_in[FRR_POS_BL] = phase_b_low_vds_i;
   assign raw_in[FRR_POS_CL] = phase_c_low_vds_i;
   assign raw_in[FRR_POS_VR] = regulator_undervoltage_i;
   assign raw_in[FRR_POS_VA] = bootstrap_a_undervolt_i;
   assign raw_in[FRR_POS_VB] = bootstrap_b_undervolt_i;
   assign raw_in[FRR_POS_VC] = bootstrap_c_undervolt_i;
   assign raw_in[FRR_LN_ESF] = stop_on_fault_enable_i;
   assign raw_in[FRR_LN_LUV] = logic_undervolt_i;
   assign raw_in[FRR_LN_OT] = overtemp_i;
   assign raw_in[FRR_LN_PRST] = reset_pin_n_i;
   assign raw_in[FRR_LN_CLK] = fault_clock_flag_i;

   frr_sync #(
      .W(FRR_SYNC_W)
   ) u_sync (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .async_i(raw_in),
      .sync_o(syn)
   );

   // Clock flag edges, filtered against short glitches.
   logic link_fall;

   frr_link_edge #(
      .FILT(FRR_FILT_CYC)
   ) u_edge (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .level_i(syn[FRR_LN_CLK]),
      .level_o(),
      .rise_o(),
      .fall_o(link_fall)
   );

   // ==========================================================
   // Condition decode
   wire [FRR_REC_W-1:0] det_s = syn[FRR_REC_W-1:0];
   wire esf_s = syn[FRR_LN_ESF];
   wire luv_s = syn[FRR_LN_LUV];
   wire ot_s = syn[FRR_LN_OT];
   wire pin_rst_s = !syn[FRR_LN_PRST];
   wire vr_s = det_s[FRR_POS_VR];
   wire [2:0] hs_s = det_s[FRR_POS_CH:FRR_POS_AH];
   wire [2:0] ls_s = det_s[FRR_POS_CL:FRR_POS_AL];
   wire any_vds = |{hs_s, ls_s};

   frr_state_type st_ff;
   frr_state_type nxt_st;
   logic [FRR_IDX_W-1:0] idx_ff;
   logic [FRR_IDX_W-1:0] nxt_idx;
   logic [FRR_REC_W-1:0] rec_ff;
   logic [FRR_REC_W-1:0] nxt_rec;
   logic short_lat_ff;
   logic nxt_short_lat;
   logic [2:0] settle_ff;
   logic [2:0] nxt_settle;

   wire boot_lat = |rec_ff[FRR_POS_VC:FRR_POS_VA];
   wire uv_show = luv_s || vr_s || boot_lat;
   wire boot_det = |det_s[FRR_POS_VC:FRR_POS_VA];
   wire in_shift = (st_ff == FRR_SHIFT);
   wire in_idle = (st_ff == FRR_IDLE);
   wire cur_bit = rec_ff[idx_ff];
   wire last_fall = in_shift && link_fall && (idx_ff == FRR_IDX_LAST);
   wire abort = luv_s || pin_rst_s;
   wire wipe = abort || last_fall;
   wire set_ok = !abort;

   // ==========================================================
   // Flag encoding: an enable of one pulls the open-drain pin low.
   function automatic logic [1:0] flag_pull(
      input logic uv,
      input logic ot,
      input logic sh
   );
      logic [1:0] pull;
      pull = 2'b11;
      if (uv) begin
         pull = 2'b00;
      end else if (ot) begin
         pull = 2'b01;
      end else if (sh) begin
         pull = 2'b10;
      end
      return pull;
   endfunction : flag_pull

   wire clk_released = !fault_clock_flag_oe_o;
   wire start_ok = clk_released && (settle_ff == FRR_SETTLE_CYC);
   wire start = in_idle && start_ok && link_fall && !abort;

   // ==========================================================
   // Record accumulation
   // Detections are ORed in; one in a readout-end clearing cycle survives, one during an abort does not.
   assign nxt_rec = (wipe ? FRR_REC_RESET : rec_ff)
                    | (set_ok ? det_s : FRR_REC_RESET);

   // Shorts latch the flag only with stop-on-fault high.
   assign nxt_short_lat = (wipe ? 1'b0 : short_lat_ff)
                          | (set_ok && esf_s && any_vds);

   // Readout can only start after the clock flag has been released
   // long enough for its pull-up level to reach the filter.
   assign nxt_settle = !clk_released ? 3'h0 :
                       (settle_ff == FRR_SETTLE_CYC) ? settle_ff :
                       settle_ff + 3'h1;

   // ==========================================================
   // Readout sequencer
   always_comb begin
      nxt_st = st_ff;
      nxt_idx = idx_ff;
      case (st_ff)
         FRR_IDLE: begin
            if (start) begin
               nxt_st = FRR_SHIFT;
               nxt_idx = FRR_IDX_FIRST;
            end
         end
         FRR_SHIFT: begin
            if (abort || last_fall) begin
               nxt_st = FRR_IDLE;
               nxt_idx = FRR_IDX_FIRST;
            end else if (link_fall) begin
               nxt_idx = idx_ff + 4'h1;
            end
         end
         default: begin
            nxt_st = FRR_IDLE;
            nxt_idx = FRR_IDX_FIRST;
         end
      endcase
   end

   // The clock flag stays released through a readout; the data flag
   // carries the selected bit, released for a one.
   logic nxt_data_oe;
   logic nxt_clk_oe;

   wire nxt_uv = luv_s || vr_s
                 || (|nxt_rec[FRR_POS_VC:FRR_POS_VA]);
   wire nxt_short = nxt_short_lat || any_vds;
   wire [1:0] nxt_pull = flag_pull(nxt_uv, ot_s, nxt_short);

   assign nxt_data_oe = (nxt_st == FRR_SHIFT) ? !nxt_rec[nxt_idx]
                        : nxt_pull[1];
   assign nxt_clk_oe = (nxt_st == FRR_SHIFT) ? 1'b0 : nxt_pull[0];

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         st_ff <= FRR_IDLE;
         idx_ff <= FRR_IDX_FIRST;
         rec_ff <= FRR_REC_RESET;
         short_lat_ff <= 1'b0;
         settle_ff <= 3'h0;
      end else begin
         st_ff <= nxt_st;
         idx_ff <= nxt_idx;
         rec_ff <= nxt_rec;
         short_lat_ff <= nxt_short_lat;
         settle_ff <= nxt_settle;
      end
   end

   // ==========================================================
   // Pin drivers
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         fault_data_flag_oe_o <= 1'b1;
         fault_clock_flag_oe_o <= 1'b1;
         fault_data_flag_o <= 1'b0;
         fault_clock_flag_o <= 1'b0;
         fault_record_o <= FRR_REC_RESET;
      end else begin
         fault_data_flag_oe_o <= nxt_data_oe;
         fault_clock_flag_oe_o <= nxt_clk_oe;
         fault_data_flag_o <= 1'b0;
         fault_clock_flag_o <= 1'b0;
         fault_record_o <= nxt_rec;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);

   property p_luv_release;
      luv_s |=> !fault_data_flag_oe_o && !fault_clock_flag_oe_o;
   endproperty
   a_luv_release: assert property (p_luv_release)
      else $error("logic undervoltage did not release both flags");

   property p_luv_clear;
      luv_s |=> (rec_ff == FRR_REC_RESET);
   endproperty
   a_luv_clear: assert property (p_luv_clear)
      else $error("logic undervoltage did not clear the record");

   property p_short_flags;
      in_idle && !start && !uv_show && !ot_s && !boot_det && any_vds
         |=> fault_data_flag_oe_o && !fault_clock_flag_oe_o;
   endproperty
   a_short_flags: assert property (p_short_flags)
      else $error("short did not show as data low, clock released");

   property p_high_set;
      hs_s[0] && set_ok |=> rec_ff[FRR_POS_AH];
   endproperty
   a_high_set: assert property (p_high_set)
      else $error("high-side A detection not recorded");

   property p_low_set;
      ls_s[2] && set_ok |=> rec_ff[FRR_POS_CL];
   endproperty
   a_low_set: assert property (p_low_set)
      else $error("low-side C detection not recorded");

   property p_keep;
      !wipe |=> ((rec_ff & $past(rec_ff)) == $past(rec_ff));
   endproperty
   a_keep: assert property (p_keep)
      else $error("record bit lost without a clear");

   property p_refuse;
      in_idle && fault_clock_flag_oe_o |=> in_idle;
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("readout started while clock flag pulled low");

   sequence s_start;
      start;
   endsequence
   sequence s_first_bit;
      in_shift && (idx_ff == FRR_IDX_FIRST)
         && (fault_data_flag_oe_o != rec_ff[FRR_POS_AH]);
   endsequence
   property p_start;
      s_start |=> s_first_bit;
   endproperty
   a_start: assert property (p_start)
      else $error("readout did not present the first bit");

   property p_present;
      in_shift && !wipe |=> in_shift && (fault_data_flag_oe_o == !cur_bit);
   endproperty
   a_present: assert property (p_present)
      else $error("data flag does not carry the selected bit");

   sequence s_end;
      last_fall && !luv_s && !vr_s && !ot_s && !any_vds && !boot_det;
   endsequence
   property p_end;
      s_end |=> in_idle && fault_data_flag_oe_o && fault_clock_flag_oe_o;
   endproperty
   a_end: assert property (p_end)
      else $error("end of readout did not pull both flags low");

   property p_vr_back;
      last_fall && vr_s && !luv_s |=> !fault_data_flag_oe_o
                                      && !fault_clock_flag_oe_o;
   endproperty
   a_vr_back: assert property (p_vr_back)
      else $error("active regulator undervoltage not shown after clear");

   property p_boot_hold;
      rec_ff[FRR_POS_VA] && !wipe |=> rec_ff[FRR_POS_VA];
   endproperty
   a_boot_hold: assert property (p_boot_hold)
      else $error("bootstrap state dropped without a clear");

   property p_vr_set;
      vr_s && set_ok |=> rec_ff[FRR_POS_VR];
   endproperty
   a_vr_set: assert property (p_vr_set)
      else $error("regulator undervoltage not recorded");

   property p_boot_set;
      det_s[FRR_POS_VC] && set_ok |=> rec_ff[FRR_POS_VC];
   endproperty
   a_boot_set: assert property (p_boot_set)
      else $error("bootstrap C undervoltage not recorded");

   property p_esf_off;
      !esf_s && any_vds && set_ok |=> |rec_ff[FRR_POS_CL:FRR_POS_AH];
   endproperty
   a_esf_off: assert property (p_esf_off)
      else $error("short not recorded with stop-on-fault off");

   property p_shift_clk;
      in_shift |-> !fault_clock_flag_oe_o;
   endproperty
   a_shift_clk: assert property (p_shift_clk)
      else $error("clock flag pulled low during a readout");

   property p_filtered;
      start |-> !$past(syn[FRR_LN_CLK]) && !$past(syn[FRR_LN_CLK], 2);
   endproperty
   a_filtered: assert property (p_filtered)
      else $error("readout started without a filtered clock fall");

   property p_ot_back;
      last_fall && ot_s && !luv_s && !vr_s && !boot_det
         |=> !fault_data_flag_oe_o && fault_clock_flag_oe_o;
   endproperty
   a_ot_back: assert property (p_ot_back)
      else $error("active overtemperature not shown after clear");

endmodule : frr_fault_record

/* File: verification/frr_ctl_model.sv */
// Behavioural model of the motor controller that reads the fault record.
`timescale 1ns/10ps
module frr_ctl_model (
   input wire logic data_wire_i,
   output logic clock_pull_o
);
   localparam int HALF_NS = 400;

   initial begin
      clock_pull_o = 1'b0;
   end

   // ==========================================================
   // Clock flag sequences
   // A single short low pulse that the device must not take as a start.
   task automatic glitch;
      clock_pull_o = 1'b1;
      #100;
      clock_pull_o = 1'b0;
   endtask : glitch

   // The caller decodes the flag pair and protects the FETs first.
   task automatic readout(output logic [9:0] rec);
      #13;
      clock_pull_o = 1'b1;
      for (int i = 0; i < 10; i++) begin
         #HALF_NS;
         clock_pull_o = 1'b0;
         #HALF_NS;
         rec[i] = data_wire_i;
         clock_pull_o = 1'b1;
      end
      #(2 * HALF_NS);
      clock_pull_o = 1'b0;
   endtask : readout
endmodule : frr_ctl_model

/* File: verification/frr_fault_record_test.sv */
// Self-checking bench for the fault record serial readout.
`timescale 1ns/10ps
module frr_fault_record_test;
   import frr_pkg::*;

   typedef struct packed {
      logic [9:0] cond;
      logic [9:0] rec;
      logic [1:0] flags;
   } frr_row_type;

   // Idle flag levels are {data, clock}: 01 short, 11 undervoltage.
   frr_row_type rows [6] = '{
      '{10'h001, 10'h001, 2'b01},
      '{10'h014, 10'h014, 2'b01},
      '{10'h009, 10'h009, 2'b01},
      '{10'h080, 10'h080, 2'b11},
      '{10'h300, 10'h300, 2'b11},
      '{10'h220, 10'h220, 2'b11}
   };

   logic sys_clk_i;
   logic reset_i;
   logic reset_pin_n;
   logic luv;
   logic ot;
   logic stop_on_fault_enable;
   logic [9:0] cond;
   logic [9:0] got;
   logic data_oe;
   logic clk_oe;
   logic ctl_pull;
   logic data_drv;
   logic clk_drv;
   logic [FRR_REC_W-1:0] rec_o;
   int n_errors = 0;
   int total_checks = 0;
   wire logic data_w = ~data_oe;
   wire logic clk_w = ~(clk_oe | ctl_pull);
   wire logic [9:0] flags_w = {8'h00, data_w, clk_w};

   frr_fault_record DUT (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .reset_pin_n_i(reset_pin_n),
      .logic_undervolt_i(luv),
      .overtemp_i(ot),
      .stop_on_fault_enable_i(stop_on_fault_enable),
      .phase_a_high_vds_i(cond[0]),
      .phase_b_high_vds_i(cond[1]),
      .phase_c_high_vds_i(cond[2]),
      .phase_a_low_vds_i(cond[3]),
      .phase_b_low_vds_i(cond[4]),
      .phase_c_low_vds_i(cond[5]),
      .regulator_undervoltage_i(cond[6]),
      .bootstrap_a_undervolt_i(cond[7]),
      .bootstrap_b_undervolt_i(cond[8]),
      .bootstrap_c_undervolt_i(cond[9]),
      .fault_clock_flag_i(clk_w),
      .fault_data_flag_o(data_drv),
      .fault_data_flag_oe_o(data_oe),
      .fault_clock_flag_o(clk_drv),
      .fault_clock_flag_oe_o(clk_oe),
      .fault_record_o(rec_o)
   );

   frr_ctl_model CTL (
      .data_wire_i(data_w),
      .clock_pull_o(ctl_pull)
   );

   // ==========================================================
   // Helpers
   task automatic end_sim;
      if (n_errors == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
      #10;
   endtask : tick

   task automatic pulse(input logic [9:0] v);
      cond = v;
      tick(4);
      cond = 10'h000;
      tick(10);
   endtask : pulse

   task automatic pin_reset;
      reset_pin_n = 1'b0;
      tick(4);
      reset_pin_n = 1'b1;
      tick(8);
   endtask : pin_reset

   initial begin
      sys_clk_i = 1'b0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end

   initial begin
      #1000000;
      n_errors++;
      end_sim();
   end

   // ==========================================================
   // Main sequence
   initial begin
      reset_i = 1'b1;
      reset_pin_n = 1'b1;
      luv = 1'b0;
      ot = 1'b0;
      stop_on_fault_enable = 1'b1;
      cond = 10'h000;
      tick(2);
      reset_i = 1'b0;
      tick(8);
      chk(rec_o, 10'h000);
      chk(flags_w, 10'h000);
      chk({8'h00, data_drv, clk_drv}, 10'h000);
      foreach (rows[k]) begin
         pulse(rows[k].cond);
         chk(rec_o, rows[k].rec);
         chk(flags_w, {8'h00, rows[k].flags});
         CTL.readout(got);
         chk(got, rows[k].rec);
         tick(2);
         chk(rec_o, 10'h000);
         chk(flags_w, 10'h000);
      end
      // Accumulation across separate events, with a glitch in between.
      pulse(10'h001);
      CTL.glitch();
      tick(8);
      chk(flags_w, 10'h001);
      pulse(10'h020);
      chk(rec_o, 10'h021);
      CTL.readout(got);
      chk(got, 10'h021);
      // Overtemperature holds the clock flag low and blocks readout.
      tick(4);
      ot = 1'b1;
      pulse(10'h001);
      chk(flags_w, 10'h002);
      CTL.readout(got);
      chk(rec_o, 10'h001);
      ot = 1'b0;
      tick(10);
      chk(flags_w, 10'h001);
      CTL.readout(got);
      chk(got, 10'h001);
      // Logic undervoltage wipes the record and releases both flags.
      tick(4);
      pulse(10'h001);
      luv = 1'b1;
      tick(8);
      chk(rec_o, 10'h000);
      chk(flags_w, 10'h003);
      luv = 1'b0;
      tick(8);
      chk(flags_w, 10'h000);
      // Regulator undervoltage still active at the end of a readout.
      cond = 10'h040;
      tick(10);
      chk(flags_w, 10'h003);
      CTL.readout(got);
      chk(got, 10'h040);
      tick(4);
      chk(flags_w, 10'h003);
      cond = 10'h000;
      tick(8);
      chk(flags_w, 10'h000);
      chk(rec_o, 10'h040);
      pin_reset();
      chk(rec_o, 10'h000);
      // Without stop-on-fault the flags follow the comparator.
      stop_on_fault_enable = 1'b0;
      cond = 10'h002;
      tick(8);
      chk(flags_w, 10'h001);
      cond = 10'h000;
      tick(8);
      chk(flags_w, 10'h000);
      chk(rec_o, 10'h002);
      pin_reset();
      chk(rec_o, 10'h000);
      // The bootstrap state latches until the reset pin clears it.
      stop_on_fault_enable = 1'b1;
      pulse(10'h100);
      chk(flags_w, 10'h003);
      pin_reset();
      chk(rec_o, 10'h000);
      chk(flags_w, 10'h000);
      // A power-cycle reset in mid-run wipes a latched short.
      pulse(10'h004);
      chk(flags_w, 10'h001);
      reset_i = 1'b1;
      tick(2);
      reset_i = 1'b0;
      tick(8);
      chk(rec_o, 10'h000);
      chk(flags_w, 10'h000);
      chk({8'h00, data_drv, clk_drv}, 10'h000);
      end_sim();
   end
endmodule : frr_fault_record_test
